// File: sim/art_src_model.sv
// Model: oscillator and comparator sources feeding the timer
`timescale 1ns/1ps
`default_nettype none
module art_src_model (
	input  wire logic [15:0] osc_half,
	input  wire logic [15:0] cmp_half,
	output logic             ext_osc_in,
	output logic             cmp1_in
);
	// Offsets keep edges away from clock edges
	initial begin
		ext_osc_in = 1'b0;
		#3;
		forever #(osc_half) ext_osc_in = ~ext_osc_in;
	end
	initial begin
		cmp1_in = 1'b0;
		#4;
		forever #(cmp_half) cmp1_in = ~cmp1_in;
	end
endmodule
`default_nettype wire

// File: sim/art_timer_props.sv
// Checker: port-level properties of the reload timer
`timescale 1ns/1ps
`default_nettype none
module art_timer_props (
	input wire logic               core_clk,
	input wire logic               srst,
	input wire art_pkg::art_addr_t reg_addr,
	input wire art_pkg::art_data_t reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire art_pkg::art_data_t reg_rdata,
	input wire logic               ext_osc_in,
	input wire logic               cmp1_in,
	input wire logic               irq
);
	import art_pkg::*;

	// ------------------------------------------------------------
	// Shadow of software-written settings
	// ------------------------------------------------------------
	logic       en_q;
	logic       ok_q;
	logic [1:0] mask_q;
	logic [1:0] clk_q;
	logic [5:0] ctrl_q;
	art_data_t  rll_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			en_q   <= 1'b0;
			mask_q <= 2'h0;
			clk_q  <= 2'h0;
			ctrl_q <= 6'h00;
			rll_q  <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				ART_OFF_IRQEN:  en_q   <= reg_wdata[ART_IRQEN_TMR];
				ART_OFF_MASK:   mask_q <= reg_wdata[1:0];
				ART_OFF_CLKCTL: clk_q  <= reg_wdata[1:0];
				ART_OFF_CTRL:   ctrl_q <= reg_wdata[5:0];
				ART_OFF_RLD_LO: rll_q  <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ok_q <= 1'b1;
		end else if (ctrl_q[4]) begin
			ok_q <= 1'b0;
		end else if (reg_wr && reg_addr == ART_OFF_RLD_LO) begin
			ok_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	unmapped_read_a: assert property (reg_rd && reg_addr > ART_OFF_MASK |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (reg_rd && reg_addr == ART_OFF_CTRL |=> reg_rdata[5:0] == $past(ctrl_q))
		else $error("control readback wrong");
	clksel_read_a: assert property (reg_rd && reg_addr == ART_OFF_CLKCTL |=> reg_rdata[1:0] == $past(clk_q))
		else $error("clock select readback wrong");
	reload_read_a: assert property (reg_rd && reg_addr == ART_OFF_RLD_LO && ok_q
		&& !ctrl_q[4] |=> reg_rdata == $past(rll_q))
		else $error("reload readback wrong");
	irq_enable_a: assert property (!en_q |-> !irq)
		else $error("irq while timer irq disabled");
	irq_mask_a: assert property (mask_q == 2'h0 |-> !irq)
		else $error("irq while fully masked");
	irq_low_gate_a: assert property (!ctrl_q[5] && !mask_q[1] |-> !irq)
		else $error("low irq without low enable");
	flag_sticky_a: assert property (irq && !reg_wr |=> irq)
		else $error("irq dropped without software");

	cover property (reg_wr && reg_addr == ART_OFF_CTRL && reg_wdata[3]);
	cover property (reg_wr && reg_addr == ART_OFF_CTRL && reg_wdata[4]);
	cover property ($rose(irq));
endmodule

bind art_timer art_timer_props art_timer_props_i (
	.core_clk   (core_clk),
	.srst       (srst),
	.reg_addr   (reg_addr),
	.reg_wdata  (reg_wdata),
	.reg_wr     (reg_wr),
	.reg_rd     (reg_rd),
	.reg_rdata  (reg_rdata),
	.ext_osc_in (ext_osc_in),
	.cmp1_in    (cmp1_in),
	.irq        (irq)
);
`default_nettype wire

// File: sim/tb.sv
// Testbench: self-checking scenarios for the reload timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb;
	import art_pkg::*;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	art_addr_t   reg_addr = 4'h0;
	art_data_t   reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	art_data_t   reg_rdata;
	logic        ext_osc_in;
	logic        cmp1_in;
	logic        irq;
	logic [15:0] osc_half = 16'h0023;
	logic [15:0] cmp_half = 16'h0041;
	int          error_cnt = 0;
	int          num_checks = 0;
	art_data_t   rv;
	art_data_t   rh;
	logic [15:0] v1;

	always #5 core_clk = ~core_clk;

	art_timer art_timer_i (
		.core_clk   (core_clk),
		.srst       (srst),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_rdata  (reg_rdata),
		.ext_osc_in (ext_osc_in),
		.cmp1_in    (cmp1_in),
		.irq        (irq)
	);
	art_src_model art_src_model_i (
		.osc_half   (osc_half),
		.cmp_half   (cmp_half),
		.ext_osc_in (ext_osc_in),
		.cmp1_in    (cmp1_in)
	);

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic wr(input art_addr_t a, input art_data_t d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input art_addr_t a, output art_data_t d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk_rd(input art_addr_t a, input art_data_t e);
		rd(a, rv);
		`CHK(rv, e)
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (irq !== 1'b1) begin
			error_cnt++;
			$display("unexpected at %0t: irq wait limit reached", $time);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 16; i++) begin
			chk_rd(art_addr_t'(i), ART_RST_BYTE);
		end
		wr(4'h9, 8'hFF);
		chk_rd(4'h9, 8'h00);
		wr(ART_OFF_CTRL, 8'hC0);
		chk_rd(ART_OFF_CTRL, 8'h00);
	endtask
	task automatic t_wide;
		wr(ART_OFF_RLD_LO, 8'h34);
		wr(ART_OFF_RLD_HI, 8'h12);
		wr(ART_OFF_CNT_LO, 8'hF0);
		wr(ART_OFF_CNT_HI, 8'hFF);
		wr(ART_OFF_CLKCTL, 8'h01);
		wr(ART_OFF_IRQEN, 8'h80);
		wr(ART_OFF_MASK, 8'h02);
		wr(ART_OFF_CTRL, 8'h04);
		repeat (20) @(posedge core_clk);
		wr(ART_OFF_CTRL, 8'h00);
		chk_rd(ART_OFF_CNT_LO, 8'h3A);
		chk_rd(ART_OFF_CNT_HI, 8'h12);
		chk_rd(ART_OFF_STAT, 8'h03);
		chk_rd(ART_OFF_CTRL, 8'hC0);
		`CHK(irq, 1'b1)
		wr(ART_OFF_IRQEN, 8'h00);
		`CHK(irq, 1'b0)
		wr(ART_OFF_IRQEN, 8'h80);
		wr(ART_OFF_MASK, 8'h00);
		`CHK(irq, 1'b0)
		wr(ART_OFF_MASK, 8'h03);
		repeat (30) @(posedge core_clk);
		`CHK(irq, 1'b1)
		wr(ART_OFF_STAT, 8'h03);
		chk_rd(ART_OFF_STAT, 8'h00);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_low;
		wr(ART_OFF_CNT_LO, 8'hFE);
		wr(ART_OFF_MASK, 8'h01);
		wr(ART_OFF_CTRL, 8'h04);
		wr(ART_OFF_CTRL, 8'h00);
		chk_rd(ART_OFF_STAT, 8'h01);
		`CHK(irq, 1'b0)
		wr(ART_OFF_CTRL, 8'h20);
		`CHK(irq, 1'b1)
		chk_rd(ART_OFF_CNT_HI, 8'h13);
		wr(ART_OFF_STAT, 8'h01);
	endtask
	task automatic t_split;
		wr(ART_OFF_RLD_LO, 8'hF0);
		wr(ART_OFF_RLD_HI, 8'hA0);
		wr(ART_OFF_CNT_LO, 8'hFE);
		wr(ART_OFF_CNT_HI, 8'hFE);
		wr(ART_OFF_CLKCTL, 8'h03);
		wr(ART_OFF_MASK, 8'h03);
		wr(ART_OFF_CTRL, 8'h08);
		repeat (3) @(posedge core_clk);
		wr(ART_OFF_CTRL, 8'h00);
		chk_rd(ART_OFF_CNT_LO, 8'hF3);
		chk_rd(ART_OFF_CNT_HI, 8'hFE);
		chk_rd(ART_OFF_STAT, 8'h01);
		`CHK(irq, 1'b0)
		wr(ART_OFF_CNT_LO, 8'h10);
		wr(ART_OFF_STAT, 8'h01);
		wr(ART_OFF_CTRL, 8'h0C);
		wr(ART_OFF_CTRL, 8'h00);
		chk_rd(ART_OFF_CNT_HI, 8'hA0);
		chk_rd(ART_OFF_CNT_LO, 8'h12);
		chk_rd(ART_OFF_STAT, 8'h02);
		`CHK(irq, 1'b1)
		wr(ART_OFF_STAT, 8'h02);
		wr(ART_OFF_CTRL, 8'h28);
		wait_irq(300);
		`CHK(irq, 1'b1)
		wr(ART_OFF_CTRL, 8'h00);
		chk_rd(ART_OFF_STAT, 8'h01);
		wr(ART_OFF_STAT, 8'h01);
	endtask
	task automatic t_src;
		logic [1:0] xs [5] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h1};
		logic [7:0] cs [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		int         ns [5] = '{118, 118, 558, 128, 8};
		for (int i = 0; i < 5; i++) begin
			wr(ART_OFF_CNT_LO, 8'h00);
			wr(ART_OFF_CNT_HI, 8'h00);
			wr(ART_OFF_CLKCTL, cs[i]);
			wr(ART_OFF_CTRL, {6'h01, xs[i]});
			repeat (ns[i]) @(posedge core_clk);
			wr(ART_OFF_CTRL, 8'h00);
			rd(ART_OFF_CNT_LO, rv);
			`CHK(rv inside {8'h09, 8'h0A, 8'h0B}, 1'b1)
		end
	endtask
	task automatic t_capture;
		logic [1:0]  xs [2] = '{2'h0, 2'h2};
		logic [15:0] dv [2] = '{16'h000D, 16'h0038};
		for (int i = 0; i < 2; i++) begin
			wr(ART_OFF_CLKCTL, 8'h01);
			wr(ART_OFF_MASK, 8'h02);
			wr(ART_OFF_CTRL, {6'h05, xs[i]});
			wr(ART_OFF_STAT, 8'h03);
			wait_irq(100);
			`CHK(irq, 1'b1)
			rd(ART_OFF_RLD_LO, rv);
			rd(ART_OFF_RLD_HI, rh);
			v1 = {rh, rv};
			wr(ART_OFF_STAT, 8'h03);
			wait_irq(100);
			rd(ART_OFF_RLD_LO, rv);
			rd(ART_OFF_RLD_HI, rh);
			`CHK({rh, rv} - v1, dv[i])
			wr(ART_OFF_CTRL, 8'h00);
		end
	endtask

	// ------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_wide();
		t_low();
		t_split();
		t_src();
		t_capture();
		stop_test();
	end
	initial begin
		#200000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
`default_nettype wire

// File: src/art_div.sv
// Module: pulse divider, one tick out per DIV pulses in
`timescale 1ns/1ps
`default_nettype none
module art_div #(
	parameter int unsigned DIV = 12
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic pulse_in,
	output logic      tick_out
);
	import art_pkg::*;

	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} art_div_s;

	art_div_s st_q;
	art_div_s st_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (pulse_in) begin
			if (st_q.cnt == LAST) begin
				st_d.cnt  = '0;
				st_d.tick = 1'b1;
			end else begin
				st_d.cnt = CW'(st_q.cnt + 1'b1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick_out = st_q.tick;
endmodule
`default_nettype wire

// File: src/art_pkg.sv
// Package: register map, field layout and constants of the reload timer
package art_pkg;

	// ----------------------------------------------------------------
	// Bus widths and types
	// ----------------------------------------------------------------
	localparam int unsigned ART_ADDR_W = 4;
	localparam int unsigned ART_DATA_W = 8;
	typedef logic [ART_ADDR_W-1:0] art_addr_t;
	typedef logic [ART_DATA_W-1:0] art_data_t;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam art_addr_t ART_OFF_CTRL   = 4'h0;
	localparam art_addr_t ART_OFF_RLD_LO = 4'h1;
	localparam art_addr_t ART_OFF_RLD_HI = 4'h2;
	localparam art_addr_t ART_OFF_CNT_LO = 4'h3;
	localparam art_addr_t ART_OFF_CNT_HI = 4'h4;
	localparam art_addr_t ART_OFF_CLKCTL = 4'h5;
	localparam art_addr_t ART_OFF_IRQEN  = 4'h6;
	localparam art_addr_t ART_OFF_STAT   = 4'h7;
	localparam art_addr_t ART_OFF_MASK   = 4'h8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned ART_CTRL_HFLAG  = 7;
	localparam int unsigned ART_CTRL_LFLAG  = 6;
	localparam int unsigned ART_CTRL_LIRQEN = 5;
	localparam int unsigned ART_CTRL_CAPEN  = 4;
	localparam int unsigned ART_CTRL_SPLIT  = 3;
	localparam int unsigned ART_CTRL_RUN    = 2;
	localparam int unsigned ART_CTRL_XSEL1  = 1;
	localparam int unsigned ART_CTRL_XSEL0  = 0;
	localparam int unsigned ART_CLK_LSYS    = 0;
	localparam int unsigned ART_CLK_HSYS    = 1;
	localparam int unsigned ART_IRQEN_TMR   = 7;
	localparam int unsigned ART_ST_LOW      = 0;
	localparam int unsigned ART_ST_HIGH     = 1;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam art_data_t   ART_RST_BYTE = 8'h00;
	localparam logic [1:0]  ART_RST_ST   = 2'h0;
	localparam art_data_t   ART_BYTE_MAX = 8'hFF;
	localparam int unsigned ART_SYS_DIV  = 12;
	localparam int unsigned ART_EXT_DIV  = 8;

	// ----------------------------------------------------------------
	// External clock choices
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ART_SRC_SYS12A = 2'b00,
		ART_SRC_EXT8   = 2'b01,
		ART_SRC_SYS12B = 2'b10,
		ART_SRC_CMP    = 2'b11
	} art_src_e;

endpackage

// File: src/art_sync.sv
// Module: two-stage synchroniser with registered rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module art_sync (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      rise_pulse
);
	import art_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} art_sync_s;

	art_sync_s st_q;
	art_sync_s st_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.s1   = async_in;
		st_d.s2   = st_q.s1;
		st_d.s3   = st_q.s2;
		st_d.rise = st_q.s2 & ~st_q.s3;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise_pulse = st_q.rise;
endmodule
`default_nettype wire

// File: src/art_timer.sv
// Module: 16-bit / dual 8-bit auto-reload timer with capture
// Notes on behaviour
// - 16-bit counter of two bytes, split selectable
// - Four count clocks, external ones synchronised
// - 16-bit wrap reloads counter, sets high flag, unless capture enabled
// - 16-bit overflow interrupts when timer enabled and high mask bit set
// - Low byte wrap interrupts if low enable, timer enabled and low mask bit set
// - Split bytes reload from own reload byte
// - Split mode run gates high byte only
// - Byte system_clock bit, else external select field
// - Split wraps set high and low flags
// - Split interrupts on high, low if enabled, each when timer enabled and its mask bit set
// - Flags cleared only by software
// - Capture on comparator edge or oscillator/8
// - Capture copies counter to reload, sets flag
`timescale 1ns/1ps
`default_nettype none
module art_timer (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire art_pkg::art_addr_t reg_addr,
	input  wire art_pkg::art_data_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output art_pkg::art_data_t     reg_rdata,
	input  wire logic              ext_osc_in,
	input  wire logic              cmp1_in,
	output logic                   irq
);
	import art_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       low_byte_irq_en;
		logic       capture_mode_en;
		logic       split_mode_sel;
		logic       run_ctrl;
		logic [1:0] ext_clock_sel;
		logic       high_byte_system_clock_sel;
		logic       low_byte_system_clock_sel;
		logic       timer_irq_en;
		art_data_t  reload_low_byte;
		art_data_t  reload_high_byte;
		art_data_t  count_low_byte;
		art_data_t  count_high_byte;
		logic [1:0] status;
		logic [1:0] mask;
		art_data_t  rdata;
	} art_state_s;

	art_state_s st_q;
	art_state_s st_d;

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	logic ext_rise;
	logic cmp_rise;
	logic tick_sys12;
	logic tick_ext8;

	logic [1:0] pin_raw;
	logic [1:0] pin_rise;

	assign pin_raw = {cmp1_in, ext_osc_in};

	for (genvar g = 0; g < 2; g++) begin : g_sync
		art_sync u_sync (
			.core_clk  (core_clk),
			.srst      (srst),
			.async_in  (pin_raw[g]),
			.rise_pulse(pin_rise[g])
		);
	end

	assign ext_rise = pin_rise[0];
	assign cmp_rise = pin_rise[1];

	art_div #(
		.DIV(ART_SYS_DIV)
	) u_div_sys (
		.core_clk(core_clk),
		.srst    (srst),
		.pulse_in(1'b1),
		.tick_out(tick_sys12)
	);

	art_div #(
		.DIV(ART_EXT_DIV)
	) u_div_ext (
		.core_clk(core_clk),
		.srst    (srst),
		.pulse_in(ext_rise),
		.tick_out(tick_ext8)
	);

	// ----------------------------------------------------------------
	// Tick selection per byte
	// ----------------------------------------------------------------
	function automatic logic pick_tick(
		input logic       sys_sel,
		input logic [1:0] xsel,
		input logic       t_sys12,
		input logic       t_ext8,
		input logic       t_cmp
	);
		logic t;
		t = 1'b0;
		if (sys_sel) begin
			t = 1'b1;
		end else begin
			unique case (art_src_e'(xsel))
				ART_SRC_SYS12A: t = t_sys12;
				ART_SRC_EXT8:   t = t_ext8;
				ART_SRC_SYS12B: t = t_sys12;
				ART_SRC_CMP:    t = t_cmp;
			endcase
		end
		return t;
	endfunction

	logic tick_lo;
	logic tick_hi;
	logic cap_event;

	always_comb begin
		tick_lo = pick_tick(st_q.low_byte_system_clock_sel, st_q.ext_clock_sel,
			tick_sys12, tick_ext8, cmp_rise);
		tick_hi = pick_tick(st_q.high_byte_system_clock_sel, st_q.ext_clock_sel,
			tick_sys12, tick_ext8, cmp_rise);
		cap_event = st_q.capture_mode_en
			& (st_q.ext_clock_sel[1] ? tick_ext8 : cmp_rise);
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	function automatic art_data_t read_reg(
		input art_addr_t  addr,
		input art_state_s s
	);
		art_data_t r;
		r = ART_RST_BYTE;
		unique case (addr)
			ART_OFF_CTRL: begin
				r[ART_CTRL_HFLAG]  = s.status[ART_ST_HIGH];
				r[ART_CTRL_LFLAG]  = s.status[ART_ST_LOW];
				r[ART_CTRL_LIRQEN] = s.low_byte_irq_en;
				r[ART_CTRL_CAPEN]  = s.capture_mode_en;
				r[ART_CTRL_SPLIT]  = s.split_mode_sel;
				r[ART_CTRL_RUN]    = s.run_ctrl;
				r[ART_CTRL_XSEL1]  = s.ext_clock_sel[1];
				r[ART_CTRL_XSEL0]  = s.ext_clock_sel[0];
			end
			ART_OFF_RLD_LO: r = s.reload_low_byte;
			ART_OFF_RLD_HI: r = s.reload_high_byte;
			ART_OFF_CNT_LO: r = s.count_low_byte;
			ART_OFF_CNT_HI: r = s.count_high_byte;
			ART_OFF_CLKCTL: begin
				r[ART_CLK_LSYS] = s.low_byte_system_clock_sel;
				r[ART_CLK_HSYS] = s.high_byte_system_clock_sel;
			end
			ART_OFF_IRQEN: r[ART_IRQEN_TMR] = s.timer_irq_en;
			ART_OFF_STAT:  r[1:0] = s.status;
			ART_OFF_MASK:  r[1:0] = s.mask;
			default:       r = ART_RST_BYTE;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Counting and flag events
	// ----------------------------------------------------------------
	logic       inc_lo;
	logic       inc_hi;
	logic       lo_wrap;
	logic       hi_wrap;
	logic [1:0] set_st;
	logic [1:0] clr_st;
	art_data_t  next_lo;
	art_data_t  next_hi;

	always_comb begin
		inc_lo  = 1'b0;
		inc_hi  = 1'b0;
		lo_wrap = 1'b0;
		hi_wrap = 1'b0;
		set_st  = 2'b00;
		next_lo = st_q.count_low_byte;
		next_hi = st_q.count_high_byte;
		if (st_q.split_mode_sel) begin
			inc_lo = tick_lo;
			inc_hi = tick_hi & st_q.run_ctrl;
			if (inc_lo) begin
				lo_wrap = (st_q.count_low_byte == ART_BYTE_MAX);
				next_lo = lo_wrap ? st_q.reload_low_byte
					: 8'(st_q.count_low_byte + 1'b1);
			end
			if (inc_hi) begin
				hi_wrap = (st_q.count_high_byte == ART_BYTE_MAX);
				next_hi = hi_wrap ? st_q.reload_high_byte
					: 8'(st_q.count_high_byte + 1'b1);
			end
			set_st[ART_ST_LOW]  = lo_wrap;
			set_st[ART_ST_HIGH] = hi_wrap;
		end else begin
			inc_lo = tick_lo & st_q.run_ctrl;
			if (inc_lo) begin
				lo_wrap = (st_q.count_low_byte == ART_BYTE_MAX);
				hi_wrap = lo_wrap & (st_q.count_high_byte == ART_BYTE_MAX);
				next_lo = 8'(st_q.count_low_byte + 1'b1);
				if (lo_wrap) begin
					next_hi = 8'(st_q.count_high_byte + 1'b1);
				end
				if (hi_wrap && !st_q.capture_mode_en) begin
					next_lo = st_q.reload_low_byte;
					next_hi = st_q.reload_high_byte;
				end
			end
			set_st[ART_ST_LOW]  = lo_wrap;
			set_st[ART_ST_HIGH] = hi_wrap & ~st_q.capture_mode_en;
		end
		if (cap_event) begin
			set_st[ART_ST_HIGH] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_comb begin
		st_d                 = st_q;
		clr_st               = 2'b00;
		st_d.count_low_byte  = next_lo;
		st_d.count_high_byte = next_hi;
		if (cap_event) begin
			st_d.reload_low_byte  = st_q.count_low_byte;
			st_d.reload_high_byte = st_q.count_high_byte;
		end
		if (reg_wr) begin
			unique case (reg_addr)
				ART_OFF_CTRL: begin
					st_d.low_byte_irq_en = reg_wdata[ART_CTRL_LIRQEN];
					st_d.capture_mode_en = reg_wdata[ART_CTRL_CAPEN];
					st_d.split_mode_sel  = reg_wdata[ART_CTRL_SPLIT];
					st_d.run_ctrl        = reg_wdata[ART_CTRL_RUN];
					st_d.ext_clock_sel   = reg_wdata[ART_CTRL_XSEL1:ART_CTRL_XSEL0];
				end
				ART_OFF_RLD_LO: st_d.reload_low_byte  = reg_wdata;
				ART_OFF_RLD_HI: st_d.reload_high_byte = reg_wdata;
				ART_OFF_CNT_LO: st_d.count_low_byte   = reg_wdata;
				ART_OFF_CNT_HI: st_d.count_high_byte  = reg_wdata;
				ART_OFF_CLKCTL: begin
					st_d.low_byte_system_clock_sel  = reg_wdata[ART_CLK_LSYS];
					st_d.high_byte_system_clock_sel = reg_wdata[ART_CLK_HSYS];
				end
				ART_OFF_IRQEN: st_d.timer_irq_en = reg_wdata[ART_IRQEN_TMR];
				ART_OFF_STAT:  clr_st = reg_wdata[1:0];
				ART_OFF_MASK:  st_d.mask = reg_wdata[1:0];
				default: begin
				end
			endcase
		end
		st_d.status = (st_q.status & ~clr_st) | set_st;
		st_d.rdata  = reg_rd ? read_reg(reg_addr, st_q) : ART_RST_BYTE;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= '{
				low_byte_irq_en:      1'b0,
				capture_mode_en:      1'b0,
				split_mode_sel:       1'b0,
				run_ctrl:             1'b0,
				ext_clock_sel:        2'b00,
				high_byte_system_clock_sel: 1'b0,
				low_byte_system_clock_sel:  1'b0,
				timer_irq_en:         1'b0,
				reload_low_byte:      ART_RST_BYTE,
				reload_high_byte:     ART_RST_BYTE,
				count_low_byte:       ART_RST_BYTE,
				count_high_byte:      ART_RST_BYTE,
				status:               ART_RST_ST,
				mask:                 ART_RST_ST,
				rdata:                ART_RST_BYTE
			};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = st_q.rdata;

	always_comb begin
		irq = st_q.timer_irq_en & (
			(st_q.status[ART_ST_HIGH] & st_q.mask[ART_ST_HIGH])
			| (st_q.status[ART_ST_LOW] & st_q.mask[ART_ST_LOW]
				& st_q.low_byte_irq_en));
	end
endmodule
`default_nettype wire
